// File: design/tstdc_map.vh
// register map and constants of the time sync measurement unit
// Overview of operation
// - one-shot mode takes one measurement per start; continuous repeats
// - two dedicated reference inputs feed the measurement unit
// - each selector offers four shared, two dedicated, feedback, time clock, sync
// - writing 1 to pop request moves next result into result fields
// - coarse and fine results are signed two's complement
`ifndef TSTDC_MAP_VH
`define TSTDC_MAP_VH
`define TSTDC_OFS_POP      12'hb2f
`define TSTDC_OFS_CTRL     12'hb20
`define TSTDC_OFS_SEL      12'hb21
`define TSTDC_OFS_STATUS   12'hb22
`define TSTDC_OFS_FINE_LO  12'hb30
`define TSTDC_OFS_FINE_HI  12'hb31
`define TSTDC_OFS_CRS_LO   12'hb32
`define TSTDC_OFS_CRS_HI   12'hb33
`define TSTDC_CTRL_EN      0
`define TSTDC_CTRL_START   1
`define TSTDC_CTRL_CONT    2
`define TSTDC_CTRL_FBDIV   3
`define TSTDC_CTRL_RESET   8'h00
`define TSTDC_SEL_RESET    8'h00
`define TSTDC_FIFO_AW      3
`define TSTDC_FIFO_DEPTH   8
`define TSTDC_FINE_W       16
`define TSTDC_CRS_W        16
`define TSTDC_FINE_STEPS   62
`endif

// File: design/tstdc_result_mem.v
// small result memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module tstdc_result_mem (
   input  wire        core_clk,
   input  wire        wrEn,
   input  wire [2:0]  wrAddr,
   input  wire [31:0] wrData,
   input  wire [2:0]  rdAddr,
   output reg  [31:0] rdData
);
   reg [31:0] memArray [0:7];
   always @(posedge core_clk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
      rdData <= memArray[rdAddr];
   end
endmodule
`default_nettype wire

// File: design/tstdc_measure.v
// time sync phase measurement unit with result queue
`timescale 1ns/10ps
`default_nettype none
`include "tstdc_map.vh"
module tstdc_measure (
   input  wire        core_clk,
   input  wire        reset_n,
   input  wire [11:0] regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [7:0]  regRdData,
   input  wire [3:0]  sharedRef,
   input  wire        dedicatedReferenceA,
   input  wire        dedicatedReferenceB,
   input  wire        loopFeedbackUndivided,
   input  wire        loopFeedbackDivided,
   input  wire        timeClkDivided,
   input  wire        timeSync,
   input  wire        fractionalOutputDividerTick,
   input  wire [5:0]  fineInterp,
   output reg         measBusy,
   output reg         resultValid
);
   // -------------------------------------------------------------------
   // selection
   // -------------------------------------------------------------------
   reg [7:0] ctrl_reg;
   reg [7:0] sel_reg;
   // choice codes: 0-3 shared, 4-5 dedicated, 6 feedback, 7 time clk, 8 sync
   function pickSource;
      input [3:0] code;
      input [3:0] sh;
      input       dA;
      input       dB;
      input       fb;
      input       tc;
      input       ts;
      begin
         case (code)
            4'h0, 4'h1, 4'h2, 4'h3: pickSource = sh[code[1:0]];
            4'h4: pickSource = dA;
            4'h5: pickSource = dB;
            4'h6: pickSource = fb;
            4'h7: pickSource = tc;
            4'h8: pickSource = ts;
            default: pickSource = 1'b0;
         endcase
      end
   endfunction
   wire feedback = ctrl_reg[`TSTDC_CTRL_FBDIV] ?
                   loopFeedbackDivided : loopFeedbackUndivided;
   wire srcA = pickSource(sel_reg[3:0], sharedRef, dedicatedReferenceA,
                          dedicatedReferenceB, feedback, timeClkDivided,
                          timeSync);
   wire srcB = pickSource(sel_reg[7:4], sharedRef, dedicatedReferenceA,
                          dedicatedReferenceB, feedback, timeClkDivided,
                          timeSync);
   // -------------------------------------------------------------------
   // measurement engine
   // -------------------------------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_ARM  = 2'b01;
   localparam ST_RUN  = 2'b10;
   reg [1:0]  state_reg;
   reg        srcA_reg;
   reg        srcB_reg;
   reg        armed_reg;
   reg [15:0] coarse_reg;
   reg [5:0]  fineA_reg;
   reg        neg_reg;
   wire       edgeA = srcA & ~srcA_reg;
   wire       edgeB = srcB & ~srcB_reg;
   wire       enable = ctrl_reg[`TSTDC_CTRL_EN];
   wire       startReq = regWr && (regAddr == `TSTDC_OFS_CTRL) &&
                         regWrData[`TSTDC_CTRL_START];
   reg        pushEn;
   reg [31:0] pushData;
   wire signed [6:0] fineDiff = {1'b0, fineInterp} - {1'b0, fineA_reg};
   always @* begin
      pushEn = 1'b0;
      pushData = 32'h00000000;
      // closing edge is the input that did not open the window
      if (state_reg == ST_RUN && (neg_reg ? edgeA : edgeB)) begin
         pushEn = 1'b1;
         // later A edge negates both parts together
         if (neg_reg) begin
            pushData = {16'h0000 - coarse_reg,
                        16'h0000 - {{9{fineDiff[6]}}, fineDiff}};
         end else begin
            pushData = {coarse_reg, {{9{fineDiff[6]}}, fineDiff}};
         end
      end
   end
   // -------------------------------------------------------------------
   // queue
   // -------------------------------------------------------------------
   reg  [2:0] wrPtr_reg;
   reg  [2:0] rdPtr_reg;
   reg  [3:0] count_reg;
   wire       full = count_reg == 4'h8;
   wire       popReq = regWr && (regAddr == `TSTDC_OFS_POP) && regWrData[0];
   wire       doPop = popReq && (count_reg != 4'h0);
   wire       doPush = pushEn && !full;
   wire [31:0] memOut;
   reg  [31:0] result_reg;
   reg         popPend_reg;
   tstdc_result_mem uMem (
      .core_clk (core_clk),
      .wrEn     (doPush),
      .wrAddr   (wrPtr_reg),
      .wrData   (pushData),
      .rdAddr   (rdPtr_reg),
      .rdData   (memOut)
   );
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= `TSTDC_CTRL_RESET;
         sel_reg <= `TSTDC_SEL_RESET;
         state_reg <= ST_IDLE;
         srcA_reg <= 1'b0;
         srcB_reg <= 1'b0;
         armed_reg <= 1'b0;
         coarse_reg <= 16'h0000;
         fineA_reg <= 6'h00;
         neg_reg <= 1'b0;
         wrPtr_reg <= 3'h0;
         rdPtr_reg <= 3'h0;
         count_reg <= 4'h0;
         result_reg <= 32'h00000000;
         popPend_reg <= 1'b0;
         measBusy <= 1'b0;
         resultValid <= 1'b0;
      end else begin
         srcA_reg <= srcA;
         srcB_reg <= srcB;
         if (regWr && regAddr == `TSTDC_OFS_CTRL) begin
            ctrl_reg <= regWrData & 8'h0d;
         end
         if (regWr && regAddr == `TSTDC_OFS_SEL) begin
            sel_reg <= regWrData;
         end
         // start counts with the enable written beside it
         if (startReq && regWrData[`TSTDC_CTRL_EN]) begin
            armed_reg <= 1'b1;
         end else if (!enable) begin
            armed_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (armed_reg && enable) begin
                  state_reg <= ST_ARM;
               end
            end
            ST_ARM: begin
               coarse_reg <= 16'h0000;
               if (!enable) begin
                  state_reg <= ST_IDLE;
               end else if (edgeA) begin
                  fineA_reg <= fineInterp;
                  neg_reg <= 1'b0;
                  state_reg <= ST_RUN;
               end else if (edgeB) begin
                  fineA_reg <= fineInterp;
                  neg_reg <= 1'b1;
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (fractionalOutputDividerTick) begin
                  coarse_reg <= coarse_reg + 16'h0001;
               end
               if (!enable) begin
                  state_reg <= ST_IDLE;
               end else if (neg_reg ? edgeA : edgeB) begin
                  if (ctrl_reg[`TSTDC_CTRL_CONT]) begin
                     state_reg <= ST_ARM;
                  end else begin
                     state_reg <= ST_IDLE;
                     armed_reg <= 1'b0;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
         if (doPush) begin
            wrPtr_reg <= wrPtr_reg + 3'h1;
         end
         if (doPop) begin
            rdPtr_reg <= rdPtr_reg + 3'h1;
         end
         count_reg <= count_reg + {3'h0, doPush} - {3'h0, doPop};
         popPend_reg <= doPop;
         if (popPend_reg) begin
            result_reg <= memOut;
         end
         measBusy <= (state_reg != ST_IDLE);
         resultValid <= (count_reg != 4'h0);
      end
   end
   // -------------------------------------------------------------------
   // read port
   // -------------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `TSTDC_OFS_CTRL:    regRdData <= ctrl_reg;
            `TSTDC_OFS_SEL:     regRdData <= sel_reg;
            `TSTDC_OFS_STATUS:  regRdData <= {3'h0, full,
                                              count_reg[2:0] | {3{full}},
                                              measBusy};
            `TSTDC_OFS_FINE_LO: regRdData <= result_reg[7:0];
            `TSTDC_OFS_FINE_HI: regRdData <= result_reg[15:8];
            `TSTDC_OFS_CRS_LO:  regRdData <= result_reg[23:16];
            `TSTDC_OFS_CRS_HI:  regRdData <= result_reg[31:24];
            default:            regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// File: verif/tstdc_measure_assertions.sv
// concurrent checks on the register port of the measurement unit
`timescale 1ns/10ps
`default_nettype none
`include "tstdc_map.vh"
module tstdc_measure_checker (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic [11:0] regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [7:0]  regRdData,
   input wire logic        measBusy,
   input wire logic        resultValid
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic popWr;
   assign popWr = regWr && regAddr == `TSTDC_OFS_POP && regWrData[0];
   property p_rd_quiet; !$past(regRd) |-> regRdData == 8'h00; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("rd data off slot");
   property p_unmapped; regRd && regAddr[11:8] != 4'hb |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped rd");
   property p_sel_back; regWr && regAddr == `TSTDC_OFS_SEL ##1 regRd && !regWr
      && regAddr == `TSTDC_OFS_SEL |=> regRdData == $past(regWrData, 2);
   endproperty
   a_sel_back: assert property (p_sel_back) else $error("sel readback");
   property p_ctrl_back; regWr && regAddr == `TSTDC_OFS_CTRL ##1 regRd && !regWr
      && regAddr == `TSTDC_OFS_CTRL |=> (regRdData & 8'h0d) ==
      ($past(regWrData, 2) & 8'h0d);
   endproperty
   a_ctrl_back: assert property (p_ctrl_back) else $error("ctrl readback");
   property p_start_busy; regWr && regAddr == `TSTDC_OFS_CTRL &&
      regWrData[1:0] == 2'b11 |-> ##[1:3] measBusy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("no busy");
   property p_stop_idle; regWr && regAddr == `TSTDC_OFS_CTRL && !regWrData[0]
      |-> ##[1:3] !measBusy;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("no abort");
   property p_pop_only; $fell(resultValid) |-> $past(popWr) || $past(popWr, 2)
      || $past(popWr, 3);
   endproperty
   a_pop_only: assert property (p_pop_only) else $error("lost entry");
   // an entry only appears as the end of a running measurement
   property p_push_busy; $rose(resultValid) |-> $past(measBusy) ||
      $past(measBusy, 2);
   endproperty
   a_push_busy: assert property (p_push_busy) else $error("stray entry");
   c_pop: cover property ($fell(resultValid));
   c_busy: cover property ($rose(measBusy));
   c_empty_pop: cover property (popWr && !resultValid);
endmodule
bind tstdc_measure tstdc_measure_checker i_chk (
   .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .measBusy(measBusy), .resultValid(resultValid)
);
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench of the measurement unit
`timescale 1ns/10ps
`default_nettype none
`include "tstdc_map.vh"
module testbench;
   logic        core_clk, reset_n, regWr, regRd, measBusy, resultValid;
   logic        rdQ, fbDiv, tick;
   logic [11:0] regAddr;
   logic [7:0]  regWrData, regRdData;
   logic [8:0]  src;
   logic [5:0]  fineInterp;
   logic [15:0] expQ[$];
   logic [31:0] resQ[$];
   logic [31:0] lastRes;
   logic [15:0] n;
   int          bad_count, check_count, k;
   // coarse tick comes from the bench; only its high cycles count
   tstdc_measure i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .sharedRef(src[3:0]), .dedicatedReferenceA(src[4]),
      .dedicatedReferenceB(src[5]), .loopFeedbackUndivided(src[6] & ~fbDiv),
      .loopFeedbackDivided(src[6] & fbDiv), .timeClkDivided(src[7]),
      .timeSync(src[8]), .fractionalOutputDividerTick(tick),
      .fineInterp(fineInterp), .measBusy(measBusy), .resultValid(resultValid));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // bus tasks and result monitor
   // ----------------------------------------
   task end_of_test;
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task bus(input logic w, r, input logic [11:0] a, input logic [7:0] d);
      regWr <= w;
      regRd <= r;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, 12'h000, 8'h00);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] m, e);
      expQ.push_back({m, e});
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 12'h000, 8'h00);
   endtask
   task cmp(input logic [7:0] m, e, g);
      check_count++;
      if ((g & m) !== (e & m)) begin
         bad_count++;
         $display("[FAIL] %0t read %h expected %h", $time, g, e);
      end
   endtask
   always @(posedge core_clk) begin
      if (rdQ === 1'b1 && expQ.size() > 0) begin
         n = expQ.pop_front();
         cmp(n[15:8], n[7:0], regRdData);
      end
      rdQ <= regRd;
   end
   // pop, give the queue its latency, then read the signed fields
   task pop3(input logic [7:0] hi);
      // an empty pop leaves the previous result in place
      if (resQ.size() > 0) begin
         lastRes = resQ.pop_front();
      end
      wr(`TSTDC_OFS_POP, 8'h01);
      bus(1'b0, 1'b0, 12'h000, 8'h00);
      rd(`TSTDC_OFS_FINE_LO, 8'hff, lastRes[7:0]);
      rd(`TSTDC_OFS_FINE_HI, 8'hff, lastRes[15:8]);
      rd(`TSTDC_OFS_CRS_LO, 8'hff, lastRes[23:16]);
      rd(`TSTDC_OFS_CRS_HI, 8'hff, hi);
   endtask
   // opening edge seen at e1; ticks set at e1..e(d-1) are counted
   task meas(input int a, b, input logic lead);
      int   d, f1, f2, c, i;
      logic t;
      d = 4 + $urandom % 20;
      f1 = $urandom % 62;
      f2 = $urandom % 62;
      c = 0;
      src[lead ? a : b] <= 1'b1;
      fineInterp <= 6'(f1);
      for (i = 1; i <= d; i++) begin
         @(posedge core_clk);
         t = i[0] || $urandom % 2;
         tick <= t;
         if (i < d) begin
            c += t;
         end
      end
      src[lead ? b : a] <= 1'b1;
      fineInterp <= 6'(f2);
      resQ.push_back({16'(lead ? c : -c), 16'(lead ? f2 - f1 : f1 - f2)});
      repeat (6) @(posedge core_clk);
      src <= 9'h000;
      repeat (6) @(posedge core_clk);
   endtask
   task wait_idle;
      int i;
      for (i = 0; i < 600 && measBusy !== 1'b0; i++) @(posedge core_clk);
      if (measBusy !== 1'b0) begin
         bad_count++;
         $display("[FAIL] %0t engine hung", $time);
         end_of_test;
      end
   endtask
   initial begin
      void'($urandom(88));
      {reset_n, regWr, regRd, tick, fbDiv, regAddr, regWrData, src} = '0;
      lastRes = 32'h00000000;
      fineInterp = 6'($urandom % 62);
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(`TSTDC_OFS_STATUS, 8'hff, 8'h00);
      rd(12'h3c0, 8'hff, 8'h00);
      wr(`TSTDC_OFS_POP, 8'h01);
      rd(`TSTDC_OFS_FINE_LO, 8'hff, 8'h00);
      bus(1'b1, 1'b0, `TSTDC_OFS_SEL, 8'h21);
      rd(`TSTDC_OFS_SEL, 8'hff, 8'h21);
      bus(1'b1, 1'b0, `TSTDC_OFS_CTRL, 8'h0c);
      rd(`TSTDC_OFS_CTRL, 8'h0d, 8'h0c);
      for (k = 0; k < 9; k++) begin
         fbDiv <= k[0];
         wr(`TSTDC_OFS_SEL, {4'((k + 1) % 9), 4'(k)});
         wr(`TSTDC_OFS_CTRL, {4'h0, k[0], 3'b011});
         meas(k, (k + 1) % 9, k[0]);
         wait_idle;
         pop3(k[0] ? 8'h00 : 8'hff);
      end
      wr(`TSTDC_OFS_SEL, 8'h54);
      // one-shot already spent: these edges must queue nothing
      meas(4, 5, 1'b1);
      void'(resQ.pop_back());
      rd(`TSTDC_OFS_STATUS, 8'h1f, 8'h00);
      wr(`TSTDC_OFS_CTRL, 8'h07);
      for (k = 0; k < 9; k++) meas(4, 5, k[0]);
      void'(resQ.pop_back());
      wr(`TSTDC_OFS_CTRL, 8'h00);
      wait_idle;
      rd(`TSTDC_OFS_STATUS, 8'h11, 8'h10);
      // ninth entry was dropped, last pop on empty keeps the eighth
      for (k = 0; k < 9; k++) pop3((k[0] || k == 8) ? 8'h00 : 8'hff);
      rd(`TSTDC_OFS_STATUS, 8'h1f, 8'h00);
      repeat (3) @(posedge core_clk);
      end_of_test;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      bad_count++;
      $display("[FAIL] %0t run too long", $time);
      end_of_test;
   end
endmodule
`default_nettype wire
